// *** src/add_and_alu_instr_exec.sv ***
// Decode and single-cycle execution of the literal and file-register add and AND instructions.
`timescale 1ns/1ps
`default_nettype none
`include "alu_exec_defs.svh"
//
// Contract
// (RULE1) Literal add puts accumulator plus literal.
// (RULE2) Literal AND into accumulator, zero flag only.
// (RULE3) File add sums accumulator and addressed register.
// (RULE4) File add destination zero accumulator, one file.
// (RULE5) File AND, zero flag only, one cycle.
// (RULE6) File AND destination one file, zero accumulator.
// (RULE7) Adds update carry, digit carry, zero; one cycle.
// (RULE8) Zero on zero result; carries from bits 7, 3.
module add_and_alu_instr_exec
    import alu_exec_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        instrValid,
    input  wire logic [13:0] instrWord,
    output logic      [6:0]  fileRdAddr,
    input  wire logic [7:0]  fileRdData,
    output file_write_t      fileWr,
    output logic      [7:0]  accOut,
    output alu_flags_t       flagsOut
);
    // The file read is combinational so one instruction finishes in one cycle.
    wire alu_op_t    opSel;
    wire logic       destFile;
    wire logic [7:0] operandB;
    wire logic [7:0] addSum;
    wire logic       addCarry;
    wire logic       addHalf;
    wire logic [7:0] andRes;
    wire logic [7:0] result;
    wire logic       isAdd;
    wire logic       toFile;

    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    alu_flags_t  flags_reg;
    alu_flags_t  flags_next;
    file_write_t wr_reg;
    file_write_t wr_next;

    assign opSel = !instrValid ? OP_NONE :
                   (instrWord[13:9] == `OPC_ADD_LIT_HI) ? OP_ADD_LIT :  // RULE1
                   (instrWord[13:8] == `OPC_AND_LIT)    ? OP_AND_LIT :  // RULE2
                   (instrWord[13:8] == `OPC_ADD_FILE)   ? OP_ADD_FILE : // RULE3
                   (instrWord[13:8] == `OPC_AND_FILE)   ? OP_AND_FILE : // RULE5
                   OP_NONE;
    assign destFile   = instrWord[`INSTR_DEST_BIT];
    assign fileRdAddr = instrWord[6:0];
    assign operandB   = (opSel == OP_ADD_LIT || opSel == OP_AND_LIT) ? instrWord[7:0] : fileRdData;
    assign andRes     = acc_reg & operandB; // RULE2 RULE5
    assign isAdd      = (opSel == OP_ADD_LIT) || (opSel == OP_ADD_FILE);
    assign result     = isAdd ? addSum : andRes;
    assign toFile     = ((opSel == OP_ADD_FILE) || (opSel == OP_AND_FILE)) && destFile; // RULE4 RULE6

    alu_adder8 u_adder
    (
        .opA          (acc_reg),
        .opB          (operandB),
        .sum          (addSum),
        .carryOut     (addCarry),
        .halfCarryOut (addHalf)
    );

    always_comb
    begin
        acc_next   = acc_reg;
        flags_next = flags_reg;
        wr_next    = '{valid: 1'b0, addr: instrWord[6:0], data: result};
        case (opSel)
            OP_ADD_LIT, OP_ADD_FILE, OP_AND_LIT, OP_AND_FILE:
            begin
                if (toFile)
                    wr_next.valid = 1'b1; // RULE4 RULE6
                else
                    acc_next = result; // RULE1 RULE4 RULE6
                flags_next.zero = (result == 8'h00); // RULE8
                if (isAdd)
                begin
                    flags_next.carry      = addCarry; // RULE7 RULE8
                    flags_next.digitCarry = addHalf;  // RULE7 RULE8
                end
            end
            default:
            begin
                acc_next = acc_reg;
            end
        endcase
    end

    // Flags and result land on the edge that ends the instruction cycle.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg   <= `ACC_RESET;
            flags_reg <= '{`FLAG_RESET, `FLAG_RESET, `FLAG_RESET};
            wr_reg    <= '0;
        end
        else
        begin
            acc_reg   <= acc_next;   // RULE7
            flags_reg <= flags_next;
            wr_reg    <= wr_next;
        end
    end

    assign accOut   = acc_reg;
    assign flagsOut = flags_reg;
    assign fileWr   = wr_reg;

    sequence s_addLit;
        instrValid && instrWord[13:9] == `OPC_ADD_LIT_HI;
    endsequence

    sequence s_andAny;
        instrValid && (instrWord[13:8] == `OPC_AND_LIT || instrWord[13:8] == `OPC_AND_FILE);
    endsequence

    a_add_lit_acc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
        s_addLit |=> accOut == 8'($past(acc_reg) + $past(instrWord[7:0])))
        else $error("Literal add gave a wrong accumulator.");

    a_and_lit_acc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        instrValid && instrWord[13:8] == `OPC_AND_LIT |=> accOut == ($past(acc_reg) & $past(instrWord[7:0])))
        else $error("Literal AND gave a wrong accumulator.");

    a_and_keeps_carry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        s_andAny |=> $stable(flagsOut.carry) && $stable(flagsOut.digitCarry))
        else $error("AND changed a carry flag.");

    a_file_add_dest: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        instrValid && instrWord[13:8] == `OPC_ADD_FILE && instrWord[7]
        |=> fileWr.valid && fileWr.data == 8'($past(acc_reg) + $past(fileRdData)) && $stable(accOut))
        else $error("File add with destination one misrouted.");

    a_file_add_acc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
        instrValid && instrWord[13:8] == `OPC_ADD_FILE && !instrWord[7]
        |=> !fileWr.valid && accOut == 8'($past(acc_reg) + $past(fileRdData)))
        else $error("File add with destination zero misrouted.");

    a_file_and_dest: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
        instrValid && instrWord[13:8] == `OPC_AND_FILE
        |=> fileWr.valid == $past(instrWord[7]) && fileWr.data == ($past(acc_reg) & $past(fileRdData)))
        else $error("File AND misrouted.");

    a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        opSel != OP_NONE |=> flagsOut.zero == ($past(result) == 8'h00))
        else $error("Zero flag does not match result.");

    a_add_carries: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        isAdd |=> flagsOut.carry == ({1'b0, $past(acc_reg)} + {1'b0, $past(operandB)} > 9'h0FF)
              && flagsOut.digitCarry == ({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(operandB[3:0])} > 5'h0F))
        else $error("Add carries wrong.");

    // Most checks below rebuild each expected value from the instruction word and the read data.
    // a_refused_holds, a_and_zero_flag and a_add_zero_flag still lean on opSel, isAdd or operandB from the decode.
    // A write that lands one cycle late is legal here, so the checks look one edge ahead.
    sequence s_fileOp;
        instrValid && (instrWord[13:8] == `OPC_ADD_FILE || instrWord[13:8] == `OPC_AND_FILE);
    endsequence

    a_refused_holds: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        opSel == OP_NONE |=> $stable(accOut) && $stable(flagsOut) && !fileWr.valid)
        else $error("Refused or idle cycle changed state.");

    a_file_wr_addr: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
        s_fileOp |=> fileWr.addr == $past(instrWord[6:0]))
        else $error("File write went to a wrong address.");

    a_and_file_acc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
        instrValid && instrWord[13:8] == `OPC_AND_FILE && !instrWord[7]
        |=> accOut == ($past(acc_reg) & $past(fileRdData)))
        else $error("File AND with destination zero gave a wrong accumulator.");

    a_file_dest_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        instrValid && (instrWord[13:8] == `OPC_ADD_FILE || instrWord[13:8] == `OPC_AND_FILE) && instrWord[7]
        |=> $stable(accOut))
        else $error("File destination changed the accumulator.");

    a_acc_dest_no_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        instrValid && (instrWord[13:8] == `OPC_ADD_FILE || instrWord[13:8] == `OPC_AND_FILE) && !instrWord[7]
        |=> !fileWr.valid)
        else $error("Accumulator destination wrote a file register.");

    a_lit_add_no_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
        s_addLit |=> !fileWr.valid)
        else $error("Literal add wrote a file register.");

    a_lit_and_no_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        instrValid && instrWord[13:8] == `OPC_AND_LIT |=> !fileWr.valid)
        else $error("Literal AND wrote a file register.");

    a_and_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        s_andAny |=> flagsOut.zero == (($past(acc_reg) & $past(operandB)) == 8'h00))
        else $error("AND zero flag wrong.");

    a_add_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        isAdd |=> flagsOut.zero == (8'($past(acc_reg) + $past(operandB)) == 8'h00))
        else $error("Add zero flag wrong.");

    a_lit_carry_out: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        s_addLit |=> flagsOut.carry == ({1'b0, $past(acc_reg)} + {1'b0, $past(instrWord[7:0])} > 9'h0FF))
        else $error("Literal add carry wrong.");

    a_lit_digit_carry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        s_addLit |=> flagsOut.digitCarry == ({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(instrWord[3:0])} > 5'h0F))
        else $error("Literal add digit carry wrong.");

    a_file_add_carry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        instrValid && instrWord[13:8] == `OPC_ADD_FILE
        |=> flagsOut.carry == ({1'b0, $past(acc_reg)} + {1'b0, $past(fileRdData)} > 9'h0FF))
        else $error("File add carry wrong.");
endmodule : add_and_alu_instr_exec
`default_nettype wire

// *** src/alu_adder8.sv ***
// Eight-bit adder that reports the carries out of bit 3 and bit 7.
`timescale 1ns/1ps
`default_nettype none
module alu_adder8
(
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    output wire logic [7:0] sum,
    output wire logic       carryOut,
    output wire logic       halfCarryOut
);
    wire logic [4:0] lowSum;
    wire logic [4:0] highSum;

    assign lowSum       = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    assign highSum      = {1'b0, opA[7:4]} + {1'b0, opB[7:4]} + {4'h0, lowSum[4]};
    assign sum          = {highSum[3:0], lowSum[3:0]};
    assign carryOut     = highSum[4];
    assign halfCarryOut = lowSum[4];
endmodule : alu_adder8
`default_nettype wire

// *** src/alu_exec_defs.svh ***
// Opcode patterns, field positions and reset values for the add and AND execute unit.
`ifndef ALU_EXEC_DEFS_SVH
`define ALU_EXEC_DEFS_SVH
`define OPC_ADD_LIT_HI   5'h1F
`define OPC_AND_LIT      6'h39
`define OPC_ADD_FILE     6'h07
`define OPC_AND_FILE     6'h05
`define INSTR_DEST_BIT   7
`define ACC_RESET        8'h00
`define FLAG_RESET       1'h0
`endif

// *** src/alu_exec_pkg.sv ***
// Types shared by the add and AND execute unit.
package alu_exec_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD_LIT,
        OP_AND_LIT,
        OP_ADD_FILE,
        OP_AND_FILE
    } alu_op_t;

    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic zero;
    } alu_flags_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } file_write_t;
endpackage : alu_exec_pkg

// *** verification/alu_exec_tb.sv ***
// Self-checking bench for the add and AND execute unit.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import alu_exec_pkg::*;
;
    logic        clk_sys;
    logic        rst_n;
    logic        instrValid;
    logic [13:0] instrWord;
    logic [6:0]  fileRdAddr;
    logic [7:0]  fileRdData;
    file_write_t fileWr;
    logic [7:0]  accOut;
    alu_flags_t  flagsOut;
    logic [7:0]  fileMem [128];
    int          errTotal;
    int          checks;

    add_and_alu_instr_exec u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .instrValid(instrValid),
        .instrWord(instrWord), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .fileWr(fileWr),
        .accOut(accOut), .flagsOut(flagsOut));

    // The file model takes writes one edge late, so a read of a just-written register needs an idle cycle.
    assign fileRdData = fileMem[fileRdAddr];
    always @(posedge clk_sys) if (fileWr.valid === 1'b1) fileMem[fileWr.addr] <= fileWr.data;
    always #12.5 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic step(input logic [13:0] w, input logic [7:0] a, input logic [2:0] f, input logic [15:0] wr);
        instrValid = 1'b1;
        instrWord  = w;
        @(negedge clk_sys);
        chk("acc", {8'h00, accOut}, {8'h00, a});
        chk("flags", {13'h0000, flagsOut}, {13'h0000, f});
        chk("fileWr", wr[15] ? fileWr : {15'h0000, fileWr.valid}, wr);
    endtask : step

    task automatic idle(input logic [13:0] w);
        instrValid = 1'b0;
        instrWord  = w;
        @(negedge clk_sys);
        chk("fileWr idle", {15'h0000, fileWr.valid}, 16'h0000);
    endtask : idle

    task automatic test_add_lit();
        step(14'h3E10, 8'h10, 3'h0, 16'h0000);
        step(14'h3F15, 8'h25, 3'h0, 16'h0000);
        step(14'h3EDB, 8'h00, 3'h7, 16'h0000);
        $display("test add_lit done");
    endtask : test_add_lit

    task automatic test_and_lit();
        step(14'h39FF, 8'h00, 3'h7, 16'h0000);
        step(14'h3EA3, 8'hA3, 3'h0, 16'h0000);
        step(14'h395F, 8'h03, 3'h0, 16'h0000);
        step(14'h3900, 8'h00, 3'h1, 16'h0000);
        $display("test and_lit done");
    endtask : test_and_lit

    task automatic test_add_file();
        step(14'h3E17, 8'h17, 3'h0, 16'h0000);
        step(14'h0744, 8'hD9, 3'h0, 16'h0000);
        idle(14'h3E17);
        step(14'h07C4, 8'hD9, 3'h4, 16'hC49B);
        step(14'h3E3E, 8'h17, 3'h6, 16'h0000);
        idle(14'h0000);
        step(14'h07C4, 8'h17, 3'h2, 16'hC4B2);
        idle(14'h0000);
        $display("test add_file done");
    endtask : test_add_file

    task automatic test_and_file();
        step(14'h05C4, 8'h17, 3'h2, 16'hC412);
        step(14'h050A, 8'h00, 3'h3, 16'h0000);
        idle(14'h3E01);
        chk("acc refused", {8'h00, accOut}, 16'h0000);
        step(14'h0144, 8'h00, 3'h3, 16'h0000);
        idle(14'h0000);
        $display("test and_file done");
    endtask : test_and_file

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (200) @(posedge clk_sys);
        errTotal++;
        report_and_stop();
    end

    initial
    begin
        clk_sys    = 1'b0;
        rst_n      = 1'b0;
        instrValid = 1'b0;
        instrWord  = 14'h0000;
        errTotal   = 0;
        checks     = 0;
        for (int i = 0; i < 128; i++) fileMem[i] = 8'h00;
        fileMem[7'h44] = 8'hC2;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        test_add_lit();
        test_and_lit();
        test_add_file();
        test_and_file();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
